// ===== logic/bsc_boot_ctrl.sv
// Purpose: Boot outcome status vector and boot control flags register
// Assumes: i_nrst is the power-on reset; loader reports arrive synchronous
// Notes:   Single clock; status and the done and fail flags are rebuilt on every boot start

`timescale 1ns/10ps

module bsc_boot_ctrl
(
   input wire logic i_clk, // CPU clock, 50 MHz
   input wire logic i_nrst, // Power-on reset, active low
   input wire bsc_pkg::bsc_sfr_req_t i_sfr_req, // SFR access port: address for reads and writes, write strobe, data
   output logic [7:0] o_sfr_rdata, // SFR read data, one cycle after addr
   input wire logic [15:0] i_xdata_addr, // XDATA read address
   output logic [7:0] o_xdata_rdata, // XDATA read data, one cycle after addr
   input wire logic i_first_general_pin, // Level of the first general pin
   input wire logic i_boot_start, // Pulse: boot sequence begins
   input wire logic [1:0] i_prog_level, // Program level of the part
   input wire logic i_user_continue_setting, // Protection byte: go on to user load
   input wire logic i_debug_force_run, // Pulse: debug host forces run bit
   input wire bsc_pkg::bsc_fac_res_t i_fac_res, // Factory load outcome
   input wire bsc_pkg::bsc_usr_res_t i_usr_res, // User block outcome
   output logic o_boot_busy, // Boot sequence in progress
   output logic o_load_user_en, // Loader may fetch user blocks
   output logic o_jump_req, // Pulse: jump to run entry address
   output logic [15:0] o_jump_addr // Jump target
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Either run-ram-code bit set, and the part not yet a run part
   function automatic logic run_allowed(input logic [7:0] flags, input logic [1:0] lvl);
      run_allowed = (flags[bsc_pkg::FL_RUN_BIT] | flags[bsc_pkg::FL_RUN_ALT_BIT])
         && (lvl != bsc_pkg::PROG_RUN);
   endfunction

   // User blocks are loaded only when nothing holds the part at factory level
   function automatic logic user_load_allowed(input logic [7:0] flags, input logic [1:0] lvl,
      input logic cont);
      user_load_allowed = (lvl != bsc_pkg::PROG_FACTORY)
         && !(lvl == bsc_pkg::PROG_USER && flags[bsc_pkg::FL_FORCE_BIT])
         && cont;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   bsc_pkg::bsc_regs_t r_reg; // Registered state
   bsc_pkg::bsc_regs_t r_next; // Next state
   logic sfr_hit; // Write aimed at the flags register

   assign sfr_hit = i_sfr_req.wr && (i_sfr_req.addr == bsc_pkg::FLAGS_SFR_ADDR);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------

   // Software writes first, hardware events after, so hardware wins a same-cycle write
   always_comb
   begin
      r_next = r_reg;
      r_next.jump_req = 1'b0;
      // Reserved bits masked off, so they stay zero forever
      if (sfr_hit)
      begin
         r_next.flags = (r_reg.flags & ~bsc_pkg::FLAGS_WMASK)
            | (i_sfr_req.wdata & bsc_pkg::FLAGS_WMASK);
      end
      // Debug host attach takes precedence over any software clear
      if (i_debug_force_run)
      begin
         r_next.flags[bsc_pkg::FL_RUN_BIT] = 1'b1;
      end
      case (r_reg.state)
         bsc_pkg::ST_IDLE:
         begin
            // Force bit is untouched here: only a flags write or power-on reset clears it
            if (i_boot_start)
            begin
               r_next.status = bsc_pkg::STATUS_RESET;
               r_next.status[bsc_pkg::ST_PIN_BIT] = i_first_general_pin;
               r_next.flags[bsc_pkg::FL_DONE_BIT] = 1'b0;
               r_next.flags[bsc_pkg::FL_FAIL_BIT] = 1'b0;
               r_next.first_seen = 1'b0;
               r_next.state = bsc_pkg::ST_FACTORY;
            end
         end
         bsc_pkg::ST_FACTORY:
         begin
            // Factory load always runs, whatever the flags say
            if (i_fac_res.valid)
            begin
               r_next.status[bsc_pkg::ST_FAC_MSB:bsc_pkg::ST_FAC_LSB] = i_fac_res.err;
               if (user_load_allowed(r_reg.flags, i_prog_level, i_user_continue_setting))
               begin
                  r_next.state = bsc_pkg::ST_USER;
               end
               else
               begin
                  r_next.state = bsc_pkg::ST_FINISH;
               end
            end
         end
         bsc_pkg::ST_USER:
         begin
            if (i_usr_res.valid)
            begin
               // First report goes to its own bit, the rest accumulate
               if (!r_reg.first_seen)
               begin
                  r_next.status[bsc_pkg::ST_FIRST_BIT] = i_usr_res.err;
                  r_next.first_seen = 1'b1;
               end
               else
               begin
                  r_next.status[bsc_pkg::ST_NEXT_BIT] = r_reg.status[bsc_pkg::ST_NEXT_BIT]
                     | i_usr_res.err;
               end
               if (i_usr_res.last)
               begin
                  r_next.state = bsc_pkg::ST_FINISH;
               end
            end
         end
         bsc_pkg::ST_FINISH:
         begin
            r_next.flags[bsc_pkg::FL_DONE_BIT] = 1'b1;
            // Fail flag looks only at the status, never at the done flag
            if (r_reg.status != bsc_pkg::STATUS_RESET)
            begin
               r_next.flags[bsc_pkg::FL_FAIL_BIT] = 1'b1;
            end
            if (run_allowed(r_next.flags, i_prog_level))
            begin
               r_next.jump_req = 1'b1;
            end
            r_next.state = bsc_pkg::ST_IDLE;
         end
         default:
         begin
            r_next.state = bsc_pkg::ST_IDLE;
         end
      endcase
      // Read data registered: status is read only, flags read back masked
      r_next.sfr_rdata = (i_sfr_req.addr == bsc_pkg::FLAGS_SFR_ADDR)
         ? (r_next.flags & bsc_pkg::FLAGS_WMASK) : 8'h00;
      r_next.xdata_rdata = (i_xdata_addr == bsc_pkg::STATUS_XDATA_ADDR)
         ? r_next.status : 8'h00;
   end

   // ----------------------------------------------------------------
   // Register
   // ----------------------------------------------------------------

   // Power-on reset and a flags write are the only things that clear the force bit
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         r_reg.state <= bsc_pkg::ST_IDLE;
         r_reg.status <= bsc_pkg::STATUS_RESET;
         r_reg.flags <= bsc_pkg::FLAGS_RESET;
         r_reg.first_seen <= 1'b0;
         r_reg.jump_req <= 1'b0;
         r_reg.sfr_rdata <= 8'h00;
         r_reg.xdata_rdata <= 8'h00;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_sfr_rdata = r_reg.sfr_rdata;
   assign o_xdata_rdata = r_reg.xdata_rdata;
   assign o_boot_busy = (r_reg.state != bsc_pkg::ST_IDLE);
   assign o_load_user_en = (r_reg.state == bsc_pkg::ST_USER);
   assign o_jump_req = r_reg.jump_req;
   assign o_jump_addr = bsc_pkg::RUN_ENTRY_ADDR;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------

   // Properties watch the registered state one edge after each event;
   // they stay quiet in reset, so the first boot after release is checked
   // like any other

   // Pin level must be the one present on the start edge, not a later one
   a_pin_sample_kept: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.state == bsc_pkg::ST_IDLE && i_boot_start)
      |=> (r_reg.status[bsc_pkg::ST_PIN_BIT] == $past(i_first_general_pin)))
      else $error("pin sample not stored at boot start");

   a_factory_code_stored: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.state == bsc_pkg::ST_FACTORY && i_fac_res.valid)
      |=> (r_reg.status[bsc_pkg::ST_FAC_MSB:bsc_pkg::ST_FAC_LSB] == $past(i_fac_res.err)))
      else $error("factory error code not stored");

   a_first_block_error: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.state == bsc_pkg::ST_USER && i_usr_res.valid && !r_reg.first_seen)
      |=> (r_reg.status[bsc_pkg::ST_FIRST_BIT] == $past(i_usr_res.err)) && r_reg.first_seen)
      else $error("first user block error not stored");

   // Bit 0 belongs to the first report only; later errors stick in bit 1
   a_later_block_error: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.state == bsc_pkg::ST_USER && i_usr_res.valid && r_reg.first_seen && i_usr_res.err)
      |=> r_reg.status[bsc_pkg::ST_NEXT_BIT] && !$changed(r_reg.status[bsc_pkg::ST_FIRST_BIT]))
      else $error("later user block error lost");

   a_fail_flag_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.state == bsc_pkg::ST_FINISH && r_reg.status != 8'h00)
      |=> r_reg.flags[bsc_pkg::FL_FAIL_BIT] && r_reg.flags[bsc_pkg::FL_DONE_BIT])
      else $error("fail flag missing after bad boot");

   a_done_clean_boot: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.state == bsc_pkg::ST_FINISH && r_reg.status == 8'h00 && !r_reg.flags[bsc_pkg::FL_FAIL_BIT]
      && !(sfr_hit && i_sfr_req.wdata[bsc_pkg::FL_FAIL_BIT]))
      |=> r_reg.flags[bsc_pkg::FL_DONE_BIT] && !r_reg.flags[bsc_pkg::FL_FAIL_BIT])
      else $error("done or fail flag wrong after clean boot");

   // Jump is one pulse, raised by the finish edge
   a_jump_when_run: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.state == bsc_pkg::ST_FINISH && i_prog_level != bsc_pkg::PROG_RUN
      && (r_reg.flags[bsc_pkg::FL_RUN_BIT] || r_reg.flags[bsc_pkg::FL_RUN_ALT_BIT]))
      |=> o_jump_req && o_jump_addr == 16'h0000 ##1 !o_jump_req)
      else $error("no single jump pulse with run bit set");

   // A run part ignores both run bits
   a_no_run_jump: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.state == bsc_pkg::ST_FINISH && i_prog_level == bsc_pkg::PROG_RUN) |=> !o_jump_req)
      else $error("jump taken on a run part");

   a_force_skips_user: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.state == bsc_pkg::ST_FACTORY && i_fac_res.valid && i_prog_level == bsc_pkg::PROG_USER
      && r_reg.flags[bsc_pkg::FL_FORCE_BIT])
      |=> r_reg.state == bsc_pkg::ST_FINISH ##1 !o_load_user_en [*2])
      else $error("user blocks loaded despite force bit");

   // Nothing but a write or power-on reset may drop the force bit
   a_force_persists: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.flags[bsc_pkg::FL_FORCE_BIT] && !sfr_hit) |=> r_reg.flags[bsc_pkg::FL_FORCE_BIT])
      else $error("force bit dropped without a write");

   a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (o_sfr_rdata & ~bsc_pkg::FLAGS_WMASK) == 8'h00 && r_reg.status[6:5] == 2'b00)
      else $error("reserved bit reads nonzero");

   // Debug attach must leave the run bit set, whatever software wrote
   a_debug_run_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_debug_force_run |=> r_reg.flags[bsc_pkg::FL_RUN_BIT])
      else $error("run bit not set by debug host");

   // A quiet write in idle lands as written, reserved bits dropped
   a_flags_write_stored: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (sfr_hit && r_reg.state == bsc_pkg::ST_IDLE && !i_boot_start && !i_debug_force_run)
      |=> r_reg.flags == ($past(i_sfr_req.wdata) & bsc_pkg::FLAGS_WMASK))
      else $error("flags write not stored as masked");

   // Finish always lands in idle with the done flag up, good boot or bad
   a_done_after_finish: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.state == bsc_pkg::ST_FINISH)
      |=> r_reg.flags[bsc_pkg::FL_DONE_BIT] && !o_boot_busy)
      else $error("done flag missing after finish");

   // Boot start clears both flags, so a stale done never hides a new boot
   a_start_clears_flags: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.state == bsc_pkg::ST_IDLE && i_boot_start && !sfr_hit)
      |=> o_boot_busy && !r_reg.flags[bsc_pkg::FL_DONE_BIT] && !r_reg.flags[bsc_pkg::FL_FAIL_BIT])
      else $error("flags not cleared at boot start");

   // Status only moves while a boot runs; firmware may read it at any time
   a_status_held: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.state == bsc_pkg::ST_IDLE && !i_boot_start) |=> $stable(r_reg.status))
      else $error("status changed outside a boot");

   // A second jump cycle would restart the CPU twice
   a_jump_single_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_jump_req |=> !o_jump_req)
      else $error("jump request longer than one cycle");

   // Continue setting off: factory values only, no user block fetched
   a_cont_off_skips: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r_reg.state == bsc_pkg::ST_FACTORY && i_fac_res.valid && !i_user_continue_setting)
      |=> r_reg.state == bsc_pkg::ST_FINISH)
      else $error("user load entered with continue setting off");

endmodule // bsc_boot_ctrl

// ===== shared/bsc_pkg.sv
// Purpose: Shared constants and types for the boot status and control block
// Assumes: One CPU clock domain, registers reached at their own fixed addresses
// Notes:   Every address, bit position, reset value and state code lives here

package bsc_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] FLAGS_SFR_ADDR = 8'hdd; // Boot control flags, SFR space
   localparam logic [15:0] STATUS_XDATA_ADDR = 16'h11ff; // Boot status vector, XDATA space
   localparam logic [15:0] RUN_ENTRY_ADDR = 16'h0000; // Code address taken after boot

   // ----------------------------------------------------------------
   // Status vector fields
   // ----------------------------------------------------------------
   localparam int ST_PIN_BIT = 7; // Pin level caught at boot start
   localparam int ST_FAC_MSB = 4; // Factory load error code, top
   localparam int ST_FAC_LSB = 2; // Factory load error code, bottom
   localparam int ST_NEXT_BIT = 1; // Later user block error
   localparam int ST_FIRST_BIT = 0; // First user block error
   localparam logic [7:0] STATUS_RESET = 8'h00; // Status after reset

   // ----------------------------------------------------------------
   // Control flag fields
   // ----------------------------------------------------------------
   localparam int FL_FORCE_BIT = 5; // Force factory behaviour
   localparam int FL_RUN_ALT_BIT = 4; // Alternate run-ram-code bit
   localparam int FL_FAIL_BIT = 2; // Boot failed flag
   localparam int FL_DONE_BIT = 1; // Boot finished flag
   localparam int FL_RUN_BIT = 0; // Run-ram-code bit
   localparam logic [7:0] FLAGS_WMASK = 8'h37; // Writable bits; reserved excluded
   localparam logic [7:0] FLAGS_RESET = 8'h00; // Flags after reset

   // ----------------------------------------------------------------
   // Program level of the part
   // ----------------------------------------------------------------
   localparam logic [1:0] PROG_FACTORY = 2'h0; // Factory part
   localparam logic [1:0] PROG_USER = 2'h1; // User programmed part
   localparam logic [1:0] PROG_RUN = 2'h2; // Final mission part

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_FACTORY = 2'b01,
      ST_USER = 2'b10,
      ST_FINISH = 2'b11
   } bsc_state_t;

   // SFR bus request from the CPU
   typedef struct packed
   {
      logic [7:0] addr;
      logic wr;
      logic [7:0] wdata;
   } bsc_sfr_req_t;

   // Factory load outcome from the loader
   typedef struct packed
   {
      logic valid;
      logic [2:0] err;
   } bsc_fac_res_t;

   // One user block outcome from the loader
   typedef struct packed
   {
      logic valid;
      logic err;
      logic last;
   } bsc_usr_res_t;

   // Whole state of the block
   typedef struct packed
   {
      bsc_state_t state;
      logic [7:0] status;
      logic [7:0] flags;
      logic first_seen;
      logic jump_req;
      logic [7:0] sfr_rdata;
      logic [7:0] xdata_rdata;
   } bsc_regs_t;

endpackage

// ===== dv/bsc_boot_ctrl_tb.sv
// Purpose: Self-checking bench for the boot status and control block
// Assumes: One 50 MHz clock; inputs change 1 ns after each rising edge
// Notes:   Expected values are built from field positions, never read back

`timescale 1ns/10ps

// Compare one value, count it, report a mismatch at once
`define CHK(nm, exp, got) \
begin \
   n_compared++; \
   if ((got) !== (exp)) \
   begin \
      fail_count++; \
      $display("unexpected %s exp=%h got=%h", nm, exp, got); \
   end \
end

module bsc_boot_ctrl_tb;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic i_clk; // 50 MHz clock
   logic i_nrst; // Reset, active low
   bsc_pkg::bsc_sfr_req_t sfr_req; // SFR access
   logic [15:0] xdata_addr; // XDATA read address
   logic pin; // First general pin level
   logic boot_start; // Boot start pulse
   logic [1:0] prog_level; // Program level
   logic user_cont; // User continue setting
   logic dbg_run; // Debug host run force
   bsc_pkg::bsc_fac_res_t fac_res; // Factory outcome
   bsc_pkg::bsc_usr_res_t usr_res; // User block outcome
   logic [7:0] sfr_rdata;
   logic [7:0] xdata_rdata;
   logic busy;
   logic load_user_en;
   logic jump_req;
   logic [15:0] jump_addr;
   int fail_count; // Mismatches seen
   int n_compared; // Comparisons made
   int jump_count; // Jump pulses seen so far

   // ----------------------------------------------------------------
   // Clock and design
   // ----------------------------------------------------------------
   initial
   begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   bsc_boot_ctrl bsc_boot_ctrl_inst
   (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_sfr_req(sfr_req),
      .o_sfr_rdata(sfr_rdata),
      .i_xdata_addr(xdata_addr),
      .o_xdata_rdata(xdata_rdata),
      .i_first_general_pin(pin),
      .i_boot_start(boot_start),
      .i_prog_level(prog_level),
      .i_user_continue_setting(user_cont),
      .i_debug_force_run(dbg_run),
      .i_fac_res(fac_res),
      .i_usr_res(usr_res),
      .o_boot_busy(busy),
      .o_load_user_en(load_user_en),
      .o_jump_req(jump_req),
      .o_jump_addr(jump_addr)
   );

   // Jump pulses counted here so a one-cycle pulse is never missed
   always @(posedge i_clk)
      if (jump_req === 1'b1)
         jump_count++;

   // ----------------------------------------------------------------
   // Access tasks; each starts and ends 1 ns after an edge
   // ----------------------------------------------------------------
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      sfr_req = '{addr: a, wr: 1'b1, wdata: d};
      @(posedge i_clk);
      #1;
      sfr_req.wr = 1'b0;
   endtask

   // Read data is registered, so it is looked at one edge after the address
   task automatic sfr_rd(input logic [7:0] exp);
      sfr_req.addr = bsc_pkg::FLAGS_SFR_ADDR;
      @(posedge i_clk);
      #1;
      `CHK("flags", exp, sfr_rdata)
   endtask

   task automatic xd_rd(input logic [15:0] a, input logic [7:0] exp);
      xdata_addr = a;
      @(posedge i_clk);
      #1;
      `CHK("status", exp, xdata_rdata)
   endtask

   // One boot: start, factory outcome, nblk user outcomes, then wait idle
   task automatic boot(input logic p, input logic [1:0] lvl, input logic cont, input logic [2:0] fe,
                       input int nblk, input logic [2:0] ue, input int jumps);
      int k;
      int j0;
      j0 = jump_count;
      pin = p;
      prog_level = lvl;
      user_cont = cont;
      boot_start = 1'b1;
      @(posedge i_clk);
      #1;
      // Pin flipped after the start edge: only the early sample may count
      boot_start = 1'b0;
      pin = ~p;
      fac_res = '{valid: 1'b1, err: fe};
      `CHK("boot_busy", 1'b1, busy)
      @(posedge i_clk);
      #1;
      fac_res = '0;
      `CHK("load_user_en", logic'(nblk > 0), load_user_en)
      for (k = 0; k < nblk; k++)
      begin
         usr_res = '{valid: 1'b1, err: ue[k], last: logic'(k == nblk - 1)};
         @(posedge i_clk);
         #1;
      end
      usr_res = '0;
      k = 0;
      while (busy !== 1'b0 && k < 20)
      begin
         @(posedge i_clk);
         #1;
         k++;
      end
      `CHK("boot_busy", 1'b0, busy)
      @(posedge i_clk);
      #1;
      `CHK("jumps", jumps, jump_count - j0)
      `CHK("jump_addr", bsc_pkg::RUN_ENTRY_ADDR, jump_addr)
   endtask

   task automatic endt(input string nm);
      $display("test %s finished", nm);
   endtask

   task automatic summarize;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      sfr_req = '0;
      xdata_addr = bsc_pkg::STATUS_XDATA_ADDR;
      {pin, boot_start, user_cont, dbg_run} = 4'h0;
      prog_level = bsc_pkg::PROG_FACTORY;
      fac_res = '0;
      usr_res = '0;
      i_nrst = 1'b0;
      repeat (5) @(posedge i_clk);
      #1;
      i_nrst = 1'b1;
      sfr_rd(8'h00);
      xd_rd(bsc_pkg::STATUS_XDATA_ADDR, 8'h00);
      endt("reset");
      // Reserved bits, unmapped places
      sfr_wr(bsc_pkg::FLAGS_SFR_ADDR, 8'hff);
      sfr_rd(8'h37);
      sfr_wr(8'hde, 8'h00);
      sfr_rd(8'h37);
      xd_rd(16'h11fe, 8'h00);
      sfr_wr(bsc_pkg::FLAGS_SFR_ADDR, 8'h00);
      sfr_rd(8'h00);
      endt("access");
      // Factory part, pin high, run bit set: jump taken
      sfr_wr(bsc_pkg::FLAGS_SFR_ADDR, 8'h01);
      boot(1'b1, bsc_pkg::PROG_FACTORY, 1'b1, 3'h0, 0, 3'h0, 1);
      xd_rd(bsc_pkg::STATUS_XDATA_ADDR, 8'h80);
      `CHK("clean_view", 8'h00, xdata_rdata & 8'h7f)
      sfr_rd(8'h07);
      endt("factory_run");
      // User part: factory code 5, first and third block fail
      sfr_wr(bsc_pkg::FLAGS_SFR_ADDR, 8'h00);
      boot(1'b0, bsc_pkg::PROG_USER, 1'b1, 3'h5, 3, 3'b101, 0);
      xd_rd(bsc_pkg::STATUS_XDATA_ADDR, 8'h17);
      sfr_rd(8'h06);
      boot(1'b0, bsc_pkg::PROG_USER, 1'b1, 3'h0, 2, 3'b000, 0);
      xd_rd(bsc_pkg::STATUS_XDATA_ADDR, 8'h00);
      sfr_rd(8'h02);
      boot(1'b0, bsc_pkg::PROG_USER, 1'b1, 3'h0, 2, 3'b010, 0);
      xd_rd(bsc_pkg::STATUS_XDATA_ADDR, 8'h02);
      // Every factory code lands in its own field only
      for (int c = 1; c < 8; c++)
      begin
         boot(1'b0, bsc_pkg::PROG_FACTORY, 1'b1, 3'(c), 0, 3'h0, 0);
         xd_rd(bsc_pkg::STATUS_XDATA_ADDR, {3'h0, 3'(c), 2'h0});
      end
      endt("user_errors");
      // Force bit beats user continue and survives later boots
      sfr_wr(bsc_pkg::FLAGS_SFR_ADDR, 8'h20);
      boot(1'b0, bsc_pkg::PROG_USER, 1'b1, 3'h0, 0, 3'h0, 0);
      sfr_rd(8'h22);
      boot(1'b0, bsc_pkg::PROG_USER, 1'b1, 3'h0, 0, 3'h0, 0);
      sfr_rd(8'h22);
      sfr_wr(bsc_pkg::FLAGS_SFR_ADDR, 8'h00);
      boot(1'b0, bsc_pkg::PROG_USER, 1'b0, 3'h0, 0, 3'h0, 0);
      endt("force_factory");
      // Run level ignores both run bits; alternate bit alone jumps
      sfr_wr(bsc_pkg::FLAGS_SFR_ADDR, 8'h11);
      boot(1'b0, bsc_pkg::PROG_RUN, 1'b0, 3'h0, 0, 3'h0, 0);
      sfr_rd(8'h13);
      sfr_wr(bsc_pkg::FLAGS_SFR_ADDR, 8'h10);
      boot(1'b0, bsc_pkg::PROG_FACTORY, 1'b1, 3'h0, 0, 3'h0, 1);
      sfr_rd(8'h12);
      endt("run_bits");
      // Debug host forcing the run bit beats a same-cycle software clear
      dbg_run = 1'b1;
      sfr_wr(bsc_pkg::FLAGS_SFR_ADDR, 8'h00);
      dbg_run = 1'b0;
      sfr_rd(8'h01);
      endt("debug_run");
      // Power-on reset also ends forced factory behaviour, as a flags write does
      sfr_wr(bsc_pkg::FLAGS_SFR_ADDR, 8'h20);
      i_nrst = 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      i_nrst = 1'b1;
      sfr_rd(8'h00);
      boot(1'b0, bsc_pkg::PROG_USER, 1'b1, 3'h0, 1, 3'h0, 0);
      endt("power_cycle");
      summarize();
   end

   // Watchdog: fires after 20000 cycles; tests need well under that
   initial
   begin
      #(20 * 20000);
      fail_count++;
      $display("unexpected watchdog exp=done got=hang");
      summarize();
   end
endmodule // bsc_boot_ctrl_tb
